/* File: design/cps_pkg.sv */
package cps_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] CPS_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CPS_OFF_EVSRC  = 8'h04;
  localparam logic [7:0] CPS_OFF_STEER  = 8'h08;
  localparam logic [7:0] CPS_OFF_PHASE  = 8'h0c;
  localparam logic [7:0] CPS_OFF_BLANK  = 8'h10;
  localparam logic [7:0] CPS_OFF_DEAD   = 8'h14;
  localparam logic [7:0] CPS_OFF_SHDN   = 8'h18;
  localparam logic [7:0] CPS_OFF_STATUS = 8'h1c;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CPS_CTRL_EN      = 0;
  localparam int CPS_CTRL_MODE    = 1;
  localparam int CPS_CTRL_CLKSEL  = 4;
  localparam int CPS_CTRL_DBASYNC = 6;
  localparam int CPS_EV_RSEL      = 0;
  localparam int CPS_EV_REDGE     = 8;
  localparam int CPS_EV_FSEL      = 16;
  localparam int CPS_EV_FEDGE     = 24;
  localparam int CPS_ST_STEER     = 0;
  localparam int CPS_ST_STATIC    = 4;
  localparam int CPS_ST_POL       = 8;
  localparam int CPS_TM_RISE      = 0;
  localparam int CPS_TM_FALL      = 8;
  localparam int CPS_SD_SRC       = 0;
  localparam int CPS_SD_RESTART   = 8;
  localparam int CPS_SD_FORCE     = 9;
  localparam int CPS_SD_RESUME    = 10;
  localparam int CPS_SD_OVR       = 16;
  localparam int CPS_SD_ACTIVE    = 31;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] CPS_RST_WORD = 32'h0000_0000;
  localparam int          CPS_REF_DIV4 = 4;

  // Operating mode codes
  typedef enum logic [2:0] {
    CPS_MODE_STEER  = 3'h0,
    CPS_MODE_SSTEER = 3'h1,
    CPS_MODE_FWD    = 3'h2,
    CPS_MODE_REV    = 3'h3,
    CPS_MODE_HALF   = 3'h4,
    CPS_MODE_PP     = 3'h5
  } cps_mode_e;

  // Shutdown override per output
  typedef enum logic [1:0] {
    CPS_OVR_HIZ  = 2'h0,
    CPS_OVR_OFF  = 2'h1,
    CPS_OVR_LOW  = 2'h2,
    CPS_OVR_HIGH = 2'h3
  } cps_ovr_e;

  typedef enum logic [1:0] {
    CPS_SD_RUN  = 2'b01,
    CPS_SD_SHUT = 2'b10
  } cps_sd_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cps_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cps_apb_rsp_s;

endpackage

/* File: design/cps_top.sv */
`timescale 1ns/1ps
`default_nettype none

module cps_top #(
  parameter int N_SRC   = 4,
  parameter int N_SHD   = 2,
  parameter int CNT_W   = 8,
  parameter int REF_DIV = 16
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire cps_pkg::cps_apb_req_s apb_req_i,
  output var  cps_pkg::cps_apb_rsp_s apb_rsp_o,
  input  wire logic [N_SRC-1:0]      event_src_i,
  input  wire logic [N_SHD-1:0]      shutdown_src_i,
  output logic [3:0]                 out_o,
  output logic [3:0]                 out_oe_o
);
  import cps_pkg::*;

  if (N_SRC < 1 || N_SRC > 8) begin : g_chk_src
    $error("N_SRC must be 1 to 8");
  end
  if (N_SHD < 1 || N_SHD > 8) begin : g_chk_shd
    $error("N_SHD must be 1 to 8");
  end
  if (CNT_W < 1 || CNT_W > 8 || REF_DIV < 2 || REF_DIV > 256) begin : g_chk_cnt
    $error("CNT_W must be 1 to 8 and REF_DIV 2 to 256");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0]  ctrl_reg;
  logic [31:0]  evsrc_reg;
  logic [31:0]  steer_reg;
  logic [31:0]  phase_reg;
  logic [31:0]  blank_reg;
  logic [31:0]  dead_reg;
  logic [31:0]  shdn_reg;
  logic [3:0]   steer_app_reg;
  cps_apb_rsp_s rsp_reg;

  wire       en       = ctrl_reg[CPS_CTRL_EN];
  wire [2:0] mode     = ctrl_reg[CPS_CTRL_MODE +: 3];
  wire [1:0] clk_sel  = ctrl_reg[CPS_CTRL_CLKSEL +: 2];
  wire       db_async = ctrl_reg[CPS_CTRL_DBASYNC];
  wire [3:0] steer_en = steer_reg[CPS_ST_STEER +: 4];
  wire [3:0] st_data  = steer_reg[CPS_ST_STATIC +: 4];
  wire [3:0] pol      = steer_reg[CPS_ST_POL +: 4];

  // ---------------------------------------------------------------
  // APB slave: pready comes in the first cycle of the access phase
  // ---------------------------------------------------------------
  wire setup   = apb_req_i.psel & ~apb_req_i.penable;
  wire access  = apb_req_i.psel & apb_req_i.penable & rsp_reg.pready;
  wire wr_stb  = access & apb_req_i.pwrite;
  wire [7:0] a = apb_req_i.paddr;
  wire mapped  = (a[1:0] == 2'h0) && (a <= CPS_OFF_STATUS);
  wire ro_hit  = (a == CPS_OFF_STATUS);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  wire wr_ctrl  = wr_stb & hit(a, CPS_OFF_CTRL);
  wire wr_evsrc = wr_stb & hit(a, CPS_OFF_EVSRC);
  wire wr_steer = wr_stb & hit(a, CPS_OFF_STEER);
  wire wr_phase = wr_stb & hit(a, CPS_OFF_PHASE);
  wire wr_blank = wr_stb & hit(a, CPS_OFF_BLANK);
  wire wr_dead  = wr_stb & hit(a, CPS_OFF_DEAD);
  wire wr_shdn  = wr_stb & hit(a, CPS_OFF_SHDN);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [N_SRC-1:0] ev_s1_reg;
  logic [N_SRC-1:0] ev_s2_reg;
  logic [N_SRC-1:0] ev_s3_reg;
  logic [N_SHD-1:0] sd_s1_reg;
  logic [N_SHD-1:0] sd_s2_reg;

  always_ff @(posedge clock_i) begin
    ev_s1_reg <= event_src_i;
    ev_s2_reg <= ev_s1_reg;
    ev_s3_reg <= ev_s2_reg;
    sd_s1_reg <= shutdown_src_i;
    sd_s2_reg <= sd_s1_reg;
  end

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  // Edge detect reads only the second stage and its delayed copy
  wire [N_SRC-1:0] ev_pulse = ev_s2_reg & ~ev_s3_reg;
  // Edge-sensed falling sources act on the high-to-low transition
  wire [N_SRC-1:0] ev_npulse = ~ev_s2_reg & ev_s3_reg;
  wire [N_SRC-1:0] r_sel    = evsrc_reg[CPS_EV_RSEL +: N_SRC];
  wire [N_SRC-1:0] r_edge   = evsrc_reg[CPS_EV_REDGE +: N_SRC];
  wire [N_SRC-1:0] f_sel    = evsrc_reg[CPS_EV_FSEL +: N_SRC];
  wire [N_SRC-1:0] f_edge   = evsrc_reg[CPS_EV_FEDGE +: N_SRC];
  // Same source may sit in both selections at once
  wire rise_lvl = |(r_sel & ((r_edge & ev_pulse) | (~r_edge & ev_s2_reg)));
  wire fall_lvl = |(f_sel & ((f_edge & ev_npulse) | (~f_edge & ~ev_s2_reg)));

  logic rise_lvl_reg;
  logic fall_lvl_reg;

  // ---------------------------------------------------------------
  // Reference tick
  // ---------------------------------------------------------------
  logic [7:0] div_reg;
  wire [7:0] div_max = (clk_sel == 2'h1) ? 8'(CPS_REF_DIV4 - 1) : 8'(REF_DIV - 1);
  wire       div_end = (div_reg >= div_max);
  wire       ref_tick = (clk_sel == 2'h0) | div_end;

  // ---------------------------------------------------------------
  // Timers: 0/1 phase, 2/3 blanking, 4/5 dead-band
  // ---------------------------------------------------------------
  localparam int NT = 6;
  logic [CNT_W-1:0] cnt_reg [NT];
  logic [NT-1:0]    t_start;
  logic [NT-1:0]    t_tick;
  logic [CNT_W-1:0] t_load  [NT];
  logic [NT-1:0]    t_zero;

  assign t_load[0] = phase_reg[CPS_TM_RISE +: CNT_W];
  assign t_load[1] = phase_reg[CPS_TM_FALL +: CNT_W];
  assign t_load[2] = blank_reg[CPS_TM_RISE +: CNT_W];
  assign t_load[3] = blank_reg[CPS_TM_FALL +: CNT_W];
  assign t_load[4] = dead_reg[CPS_TM_RISE +: CNT_W];
  assign t_load[5] = dead_reg[CPS_TM_FALL +: CNT_W];
  // Delay-element dead-band ignores the reference selection and runs on every cycle
  assign t_tick = {{2{db_async | ref_tick}}, {4{ref_tick}}};

  for (genvar k = 0; k < NT; k++) begin : g_tmr
    assign t_zero[k] = (cnt_reg[k] == '0);
    always_ff @(posedge clock_i) begin
      if (rst_i | ~en) begin
        cnt_reg[k] <= '0;
      end else if (t_start[k]) begin
        cnt_reg[k] <= t_load[k];
      end else if (t_tick[k] && !t_zero[k]) begin
        cnt_reg[k] <= cnt_reg[k] - 1'b1;
      end
    end
  end

  // Blanking hides events of the other kind while its timer runs
  wire rise_evt = en & rise_lvl & ~rise_lvl_reg & t_zero[3];
  wire fall_evt = en & fall_lvl & ~fall_lvl_reg & t_zero[2];

  logic r_pend_reg;
  logic f_pend_reg;
  logic prim_reg;
  logic pp_phase_reg;

  wire p_rise = r_pend_reg & t_zero[0];
  wire p_fall = f_pend_reg & t_zero[1] & ~p_rise;

  assign t_start = {p_fall, p_rise, fall_evt, rise_evt, fall_evt, rise_evt};

  // Primary rises after rising dead time, complement after falling dead time
  wire pri = prim_reg & t_zero[4];
  wire cmp = ~prim_reg & t_zero[5];

  // ---------------------------------------------------------------
  // Shutdown state
  // ---------------------------------------------------------------
  cps_sd_e sd_state_reg;
  cps_sd_e sd_state_next;
  wire sd_cause = |(sd_s2_reg & shdn_reg[CPS_SD_SRC +: N_SHD]);
  wire sd_force = wr_shdn & apb_req_i.pwdata[CPS_SD_FORCE];
  wire sd_resume = wr_shdn & apb_req_i.pwdata[CPS_SD_RESUME];
  wire sd_auto = shdn_reg[CPS_SD_RESTART] & rise_evt;

  always_comb begin
    sd_state_next = sd_state_reg;
    unique case (sd_state_reg)
      CPS_SD_RUN: begin
        if (sd_cause | sd_force) begin
          sd_state_next = CPS_SD_SHUT;
        end
      end
      CPS_SD_SHUT: begin
        // A live cause holds shutdown over any resume request
        if (!sd_cause && !sd_force && (sd_resume || sd_auto)) begin
          sd_state_next = CPS_SD_RUN;
        end
      end
      default: sd_state_next = CPS_SD_SHUT;
    endcase
  end

  wire shut = (sd_state_reg == CPS_SD_SHUT);

  // ---------------------------------------------------------------
  // Output steering
  // ---------------------------------------------------------------
  // Index 0..3 are outputs A..D
  function automatic logic [3:0] mode_data(input logic [2:0] m, input logic p, input logic c,
                                           input logic ph);
    unique case (m)
      CPS_MODE_STEER,
      CPS_MODE_SSTEER: mode_data = {4{p}};
      CPS_MODE_FWD:    mode_data = {p, 1'b0, 1'b0, 1'b1};
      CPS_MODE_REV:    mode_data = {1'b0, 1'b1, p, 1'b0};
      CPS_MODE_HALF:   mode_data = {c, p, c, p};
      CPS_MODE_PP:     mode_data = {p & ~ph, p & ph, p & ~ph, p & ph};
      default:         mode_data = 4'h0;
    endcase
  endfunction

  wire [3:0] mod_data = mode_data(mode, pri, cmp, pp_phase_reg) ^ pol;
  // Static data bypasses the rising-event hold
  wire [3:0] run_data = (steer_app_reg & mod_data) | (~steer_app_reg & st_data);
  wire [3:0] off_data = (steer_app_reg & pol) | (~steer_app_reg & st_data);
  logic [3:0] out_next;
  logic [3:0] oe_next;

  for (genvar k = 0; k < 4; k++) begin : g_pin
    wire [1:0] ovr = shdn_reg[CPS_SD_OVR + 2*k +: 2];
    assign out_next[k] = ~en ? 1'b0 :
                         ~shut ? run_data[k] :
                         (ovr == CPS_OVR_HIGH) ? 1'b1 :
                         (ovr == CPS_OVR_OFF) ? off_data[k] : 1'b0;
    assign oe_next[k] = en & (~shut | (ovr != CPS_OVR_HIZ));
  end

  // Sync steered mode waits for a rising event; other modes follow the register
  wire [3:0] steer_app_next = ((mode == CPS_MODE_SSTEER) && !rise_evt) ? steer_app_reg : steer_en;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire [31:0] status = {19'h0, shut, steer_app_reg, 2'h0, pp_phase_reg, prim_reg, out_o};
  wire [31:0] shdn_rd = {shut, shdn_reg[30:0]};
  wire [31:0] rd_mux = hit(a, CPS_OFF_CTRL)  ? ctrl_reg  :
                       hit(a, CPS_OFF_EVSRC) ? evsrc_reg :
                       hit(a, CPS_OFF_STEER) ? steer_reg :
                       hit(a, CPS_OFF_PHASE) ? phase_reg :
                       hit(a, CPS_OFF_BLANK) ? blank_reg :
                       hit(a, CPS_OFF_DEAD)  ? dead_reg  :
                       hit(a, CPS_OFF_SHDN)  ? shdn_rd   :
                       hit(a, CPS_OFF_STATUS) ? status   : 32'h0;
  wire err_next = ~mapped | (ro_hit & apb_req_i.pwrite);

  // ---------------------------------------------------------------
  // Sequential
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_reg      <= CPS_RST_WORD;
      evsrc_reg     <= CPS_RST_WORD;
      steer_reg     <= CPS_RST_WORD;
      phase_reg     <= CPS_RST_WORD;
      blank_reg     <= CPS_RST_WORD;
      dead_reg      <= CPS_RST_WORD;
      shdn_reg      <= CPS_RST_WORD;
      rsp_reg       <= '0;
    end else begin
      rsp_reg.pready <= setup;
      if (setup) begin
        rsp_reg.prdata  <= apb_req_i.pwrite ? 32'h0 : rd_mux;
        rsp_reg.pslverr <= err_next;
      end
      if (wr_ctrl) begin
        ctrl_reg <= {25'h0, apb_req_i.pwdata[6:0]};
      end
      if (wr_evsrc) begin
        evsrc_reg <= apb_req_i.pwdata;
      end
      if (wr_steer) begin
        steer_reg <= {20'h0, apb_req_i.pwdata[11:0]};
      end
      if (wr_phase) begin
        phase_reg <= {16'h0, apb_req_i.pwdata[15:0]};
      end
      if (wr_blank) begin
        blank_reg <= {16'h0, apb_req_i.pwdata[15:0]};
      end
      if (wr_dead) begin
        dead_reg <= {16'h0, apb_req_i.pwdata[15:0]};
      end
      // Force and resume are actions, not stored
      if (wr_shdn) begin
        shdn_reg <= {8'h0, apb_req_i.pwdata[23:16], 7'h0, apb_req_i.pwdata[8:0] & 9'h1ff};
        shdn_reg[CPS_SD_FORCE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i | ~en) begin
      div_reg      <= 8'h0;
      rise_lvl_reg <= 1'b0;
      fall_lvl_reg <= 1'b0;
      r_pend_reg   <= 1'b0;
      f_pend_reg   <= 1'b0;
      prim_reg     <= 1'b0;
      pp_phase_reg <= 1'b0;
    end else begin
      div_reg      <= div_end ? 8'h0 : div_reg + 8'h1;
      rise_lvl_reg <= rise_lvl;
      fall_lvl_reg <= fall_lvl;
      r_pend_reg   <= rise_evt | (r_pend_reg & ~p_rise);
      f_pend_reg   <= fall_evt | (f_pend_reg & ~p_fall);
      if (p_rise) begin
        prim_reg     <= 1'b1;
        pp_phase_reg <= ~pp_phase_reg;
      end else if (p_fall) begin
        prim_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sd_state_reg  <= CPS_SD_RUN;
      steer_app_reg <= 4'h0;
      out_o         <= 4'h0;
      out_oe_o      <= 4'h0;
    end else begin
      sd_state_reg  <= sd_state_next;
      steer_app_reg <= steer_app_next;
      out_o         <= out_next;
      out_oe_o      <= oe_next;
    end
  end

  assign apb_rsp_o = rsp_reg;

endmodule

`default_nettype wire

/* File: bench/cps_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_top_sva #(
  parameter int N_SRC = 4,
  parameter int N_SHD = 2
) (
  input wire logic                  clock_i,
  input wire logic                  rst_i,
  input wire cps_pkg::cps_apb_req_s apb_req_i,
  input wire cps_pkg::cps_apb_rsp_s apb_rsp_o,
  input wire logic [N_SRC-1:0]      event_src_i,
  input wire logic [N_SHD-1:0]      shutdown_src_i,
  input wire logic [3:0]            out_o,
  input wire logic [3:0]            out_oe_o
);
  import cps_pkg::*;
  // ----------------------------------------------
  // Bus decode seen from the pins
  // ----------------------------------------------
  wire logic setup = apb_req_i.psel && !apb_req_i.penable;
  wire logic bad   = (apb_req_i.paddr[1:0] != 2'h0) || (apb_req_i.paddr > CPS_OFF_STATUS);
  wire logic ro_wr = apb_req_i.pwrite && (apb_req_i.paddr == CPS_OFF_STATUS);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_ready_after_setup: assert property (setup |=> apb_rsp_o.pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (apb_rsp_o.pready |-> apb_req_i.psel && apb_req_i.penable)
    else $error("pready outside access phase");
  a_bad_addr_err: assert property (setup && (bad || ro_wr) |=> apb_rsp_o.pslverr)
    else $error("pslverr missing");
  a_good_addr_ok: assert property (setup && !bad && !ro_wr |=> !apb_rsp_o.pslverr)
    else $error("pslverr on a valid access");
  a_bad_read_zero: assert property (setup && bad && !apb_req_i.pwrite |=> apb_rsp_o.prdata == 32'h0)
    else $error("refused read returned data");
  a_resp_hold: assert property (!setup |=> $stable(apb_rsp_o.prdata) && $stable(apb_rsp_o.pslverr))
    else $error("response changed without setup");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> out_o == 4'h0 && out_oe_o == 4'h0 && !apb_rsp_o.pready)
    else $error("outputs active after reset");
  a_hiz_quiet: assert property ((out_oe_o | ~out_o) == 4'hf)
    else $error("output high while released");
endmodule
bind cps_top cps_top_sva #(.N_SRC(N_SRC), .N_SHD(N_SHD)) u_cps_top_sva (
  .clock_i(clock_i), .rst_i(rst_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
  .event_src_i(event_src_i), .shutdown_src_i(shutdown_src_i), .out_o(out_o), .out_oe_o(out_oe_o));
`default_nettype wire

/* File: bench/cps_gate_drv.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_gate_drv (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] drive_i,
  input  wire logic [3:0] drive_oe_i,
  input  wire logic       fault_cmd_i,
  output logic      [3:0] pin_o,
  output logic      [1:0] fault_o
);
  // ----------------------------------------------
  // Gate inputs have pull-downs: a released pin reads low
  // ----------------------------------------------
  assign pin_o = drive_i & drive_oe_i;
  // Desaturation sense lags by a cycle; second cause is wired off
  always_ff @(posedge clock_i) begin
    if (rst_i) fault_o <= 2'h0;
    else fault_o <= {1'b0, fault_cmd_i};
  end
endmodule
`default_nettype wire

/* File: bench/complementary_pwm_steering_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module complementary_pwm_steering_tb_top;
  import cps_pkg::*;
  logic         clock_i = 1'b0;
  logic         rst_i   = 1'b1;
  cps_apb_req_s req     = '0;
  cps_apb_rsp_s rsp;
  logic [3:0]   src     = 4'h0;
  logic [3:0]   out, oe, pin, p1;
  logic [1:0]   fault;
  logic         flt     = 1'b0;
  int           n_fail  = 0;
  int           samples_checked = 0;
  int           cycles  = 0;
  logic [2:0]   md_t [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
  logic [3:0]   lo_t [4] = '{4'h0, 4'h1, 4'h4, 4'ha};
  logic [3:0]   hi_t [4] = '{4'hf, 4'h9, 4'h6, 4'h5};
  always #2.5 clock_i = ~clock_i;
  cps_top #(.REF_DIV(2)) u_cps_top (.clock_i(clock_i), .rst_i(rst_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .event_src_i(src), .shutdown_src_i(fault), .out_o(out), .out_oe_o(oe));
  cps_gate_drv u_cps_gate_drv (.clock_i(clock_i), .rst_i(rst_i), .drive_i(out), .drive_oe_i(oe),
    .fault_cmd_i(flt), .pin_o(pin), .fault_o(fault));
  // ----------------------------------------------
  // Tasks
  // ----------------------------------------------
  task automatic results;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] e, input logic err);
    @(posedge clock_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock_i);
    req.penable <= 1'b1;
    do @(posedge clock_i); while (rsp.pready !== 1'b1);
    req <= '0;
    chk({31'h0, rsp.pslverr}, {31'h0, err});
    if (!w) chk(rsp.prdata & m, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0, '0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, '0, m, e, 1'b0);
  endtask
  // Twelve cycles cover sync, edge detect, timer and output stages
  task automatic wt(input logic v);
    src <= {3'h0, v};
    repeat (12) @(posedge clock_i);
  endtask
  task automatic drv(input logic v, input logic [3:0] e);
    wt(v);
    chk({28'h0, out}, {28'h0, e});
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end
  // ----------------------------------------------
  // Main sequence
  // ----------------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk({oe, out}, 8'h00);
    rd(CPS_OFF_CTRL, '1, 32'h0);
    apb(1'b0, 8'h20, '0, '1, 32'h0, 1'b1);
    apb(1'b0, 8'h06, '0, '1, 32'h0, 1'b1);
    apb(1'b1, CPS_OFF_STATUS, 32'h1, '0, '0, 1'b1);
    wr(CPS_OFF_EVSRC, 32'h0001_0001);
    rd(CPS_OFF_EVSRC, '1, 32'h0001_0001);
    wr(CPS_OFF_STEER, 32'h0000_0025);
    wr(CPS_OFF_CTRL, 32'h1);
    drv(1'b1, 4'h7);
    drv(1'b0, 4'h2);
    chk(oe, 4'hf);
    wr(CPS_OFF_STEER, 32'h0000_0085);
    repeat (3) @(posedge clock_i);
    chk(out, 4'h8);
    wr(CPS_OFF_STEER, 32'h0000_0105);
    repeat (3) @(posedge clock_i);
    chk(out, 4'h1);
    wr(CPS_OFF_STEER, 32'h0000_0005);
    wr(CPS_OFF_CTRL, 32'h3);
    wr(CPS_OFF_STEER, 32'h0000_0041);
    repeat (3) @(posedge clock_i);
    rd(CPS_OFF_STATUS, 32'hf00, 32'h500);
    chk(out, 4'h0);
    drv(1'b1, 4'h5);
    rd(CPS_OFF_STATUS, 32'hf00, 32'h100);
    drv(1'b0, 4'h4);
    // Static data alone changes; no rising event in between
    wr(CPS_OFF_STEER, 32'h0000_0021);
    repeat (3) @(posedge clock_i);
    chk(out, 4'h2);
    wr(CPS_OFF_CTRL, 32'h1);
    wr(CPS_OFF_STEER, 32'h0000_000f);
    for (int i = 0; i < 4; i++) begin
      wr(CPS_OFF_CTRL, {28'h0, md_t[i], 1'b1});
      drv(1'b0, lo_t[i]);
      drv(1'b1, hi_t[i]);
    end
    wr(CPS_OFF_CTRL, 32'hb);
    drv(1'b0, 4'h0);
    wt(1'b1);
    p1 = out;
    drv(1'b0, 4'h0);
    wt(1'b1);
    chk(out ^ p1, 4'hf);
    chk({31'h0, p1 == 4'h5 || p1 == 4'ha}, 32'h1);
    wr(CPS_OFF_CTRL, 32'h9);
    wt(1'b0);
    wr(CPS_OFF_SHDN, 32'h004b_0001);
    flt <= 1'b1;
    repeat (12) @(posedge clock_i);
    chk(out[1:0], 2'h1);
    chk(oe[2:0], 3'h3);
    chk(pin, 4'h1);
    rd(CPS_OFF_SHDN, 32'h8000_0000, 32'h8000_0000);
    flt <= 1'b0;
    repeat (6) @(posedge clock_i);
    wr(CPS_OFF_SHDN, 32'h004b_0401);
    repeat (6) @(posedge clock_i);
    rd(CPS_OFF_SHDN, 32'h8000_0000, 32'h0);
    chk(out, 4'ha);
    // Forced shutdown left by auto-restart at the next rising event
    wr(CPS_OFF_SHDN, 32'h004b_0301);
    rd(CPS_OFF_SHDN, 32'h8000_0000, 32'h8000_0000);
    drv(1'b1, 4'h5);
    rd(CPS_OFF_SHDN, 32'h8000_0000, 32'h0);
    // Edge-sensed source: one phase flip per rising transition
    wr(CPS_OFF_EVSRC, 32'h0101_0101);
    wr(CPS_OFF_CTRL, 32'hb);
    drv(1'b0, 4'h0);
    wt(1'b1);
    p1 = out;
    drv(1'b0, 4'h0);
    wt(1'b1);
    chk(out ^ p1, 4'hf);
    // Rise phase delay of 4 ticks at one tick per two cycles
    wr(CPS_OFF_EVSRC, 32'h0001_0001);
    wr(CPS_OFF_CTRL, 32'h21);
    wr(CPS_OFF_PHASE, 32'h0000_0004);
    drv(1'b0, 4'h0);
    wt(1'b1);
    chk(out, 4'h0);
    repeat (2) @(posedge clock_i);
    chk(out, 4'hf);
    drv(1'b0, 4'h0);
    // Delay-element dead-band counts every cycle despite the slow tick
    wr(CPS_OFF_PHASE, 32'h0);
    wr(CPS_OFF_DEAD, 32'h0000_0004);
    wr(CPS_OFF_CTRL, 32'h61);
    src <= 4'h1;
    repeat (6) @(posedge clock_i);
    chk(out, 4'h0);
    repeat (6) @(posedge clock_i);
    chk(out, 4'hf);
    // A falling event inside the rise blanking window is ignored
    wr(CPS_OFF_DEAD, 32'h0);
    wr(CPS_OFF_CTRL, 32'h1);
    wr(CPS_OFF_BLANK, 32'h0000_0020);
    drv(1'b0, 4'h0);
    drv(1'b1, 4'hf);
    drv(1'b0, 4'hf);
    wr(CPS_OFF_BLANK, 32'h0);
    wt(1'b1);
    drv(1'b0, 4'h0);
    results();
  end
endmodule
`default_nettype wire
